/* inc/pmm_pkg.sv */
// Package with register map, frame codes and timing constants.
package pmm_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int PREAMBLE_BITS = 32;
	localparam logic [1:0] START_PAT = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] TA_WRITE = 2'h2;
	localparam logic [4:0] BCAST_ADDR = 5'h00;
	localparam int STATUS_NOPRE_BIT = 6;
	localparam logic [4:0] REG_CONTROL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h01;
	localparam logic [4:0] REG_ID_HIGH = 5'h02;
	localparam logic [4:0] REG_ID_LOW = 5'h03;
	localparam logic [4:0] REG_ADVERTISE = 5'h04;
	localparam logic [4:0] REG_PARTNER = 5'h05;
	localparam logic [4:0] REG_EXPANSION = 5'h06;
	localparam logic [4:0] REG_NEXT_PAGE = 5'h07;
	localparam logic [4:0] REG_VENDOR_ONE = 5'h1C;
	localparam logic [4:0] REG_VENDOR_TWO = 5'h1D;
	localparam logic [4:0] REG_VENDOR_THREE = 5'h1E;
	localparam logic [15:0] RST_CONTROL = 16'h3000;
	localparam logic [15:0] RST_STATUS = 16'h7849;
	localparam logic [15:0] RST_ADVERTISE = 16'h01E1;
	localparam logic [15:0] RST_PARTNER = 16'h0000;
	localparam logic [15:0] RST_EXPANSION = 16'h0000;
	localparam logic [15:0] RST_NEXT_PAGE = 16'h0000;
	localparam logic [15:0] RST_VENDOR_ONE = 16'h0000;
	localparam logic [15:0] RST_VENDOR_TWO = 16'h1000;
	localparam logic [15:0] RST_VENDOR_THREE = 16'h0000;
	localparam int CTRL_RESET_BIT = 15;
	localparam int CTRL_RESTART_BIT = 9;
	localparam int CTRL_PWRDN_BIT = 11;
	localparam logic [15:0] CTRL_RW_MASK = 16'hFF80;
	localparam int MDC_MAX_KHZ = 12500;
	localparam int PCLK_KHZ = 200000;
	localparam int MDC_HALF_CYC = (PCLK_KHZ + 2 * MDC_MAX_KHZ - 1)
		/ (2 * MDC_MAX_KHZ);
	localparam logic [31:0] APB_CMD = 32'h0000_0000;
	localparam logic [31:0] APB_WDATA = 32'h0000_0004;
	localparam logic [31:0] APB_RDATA = 32'h0000_0008;
	localparam logic [31:0] APB_STATUS = 32'h0000_000C;
	// Identifier values are arbitrary.
	localparam logic [15:0] ID_HIGH_VAL = 16'h1234;
	localparam logic [15:0] ID_LOW_VAL = 16'h5678;
endpackage

/* inc/pmm_if.sv */
// Interface for the management clock and the shared data line.
`timescale 1ns/1ps
interface pmm_if;
	logic mdc;
	logic mdio_host_o;
	logic mdio_host_oe;
	logic mdio_dev_o;
	logic mdio_dev_oe;
	wire  mdio_i;
	assign mdio_i = mdio_host_oe ? mdio_host_o :
		mdio_dev_oe ? mdio_dev_o : 1'b1;
	modport device (input mdc, input mdio_i, output mdio_dev_o,
		output mdio_dev_oe);
	modport host (output mdc, input mdio_i, output mdio_host_o,
		output mdio_host_oe);
endinterface

/* hw/pmm_device.sv */
// Management slave with its 32 location register set.
// How it works
// R1 - Controller keeps management clock at most 12.5MHz.
// R2 - Fields go in frame order.
// R3 - Frames run whole without pause.
// R4 - Full preamble is thirty-two ones.
// R5 - Frames without preamble accepted; status bit6 set.
// R6 - Start pattern 01 aligns field decoding.
// R7 - Opcode 10 reads, 01 writes.
// R8 - Five bit address, MSB first, must match.
// R9 - Address zero is broadcast.
// R10 - Five bit register address, MSB first.
// R11 - Write turnaround is one then zero.
// R12 - Read turnaround: release, then device zero.
// R13 - Sixteen data bits, bit 15 first.
// R14 - Sixteen bit registers with reset defaults.
// R15 - Location 5 shows base or next page.
// R16 - Locations 28 to 30 hold device settings.
// R17 - Station address captured from straps at reset.
// R18 - Management works during powerdown.
// R19 - Release line after read; ignore others.
// R20 - Sample on rising edge, launch after it.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module pmm_device (
	input  wire logic        pclk,
	input  wire logic        presetn,
	pmm_if.device            link,
	input  wire logic [4:0]  station_address_strap,
	input  wire logic [15:0] partner_base_page,
	input  wire logic [15:0] partner_next_page,
	input  wire logic        next_page_phase,
	output logic      [15:0] control_out,
	output logic             powerdown
);
	typedef enum logic [2:0] {
		PMM_IDLE = 3'h0,
		PMM_OP   = 3'h1,
		PMM_ADDR = 3'h3,
		PMM_TA   = 3'h2,
		PMM_DATA = 3'h6
	} pmm_state_t;

	logic [1:0]  mdc_sync_ff;
	logic [1:0]  mdio_sync_ff;
	logic        mdc_prev_ff;
	logic [4:0]  strap_meta_ff;
	logic [4:0]  strap_sync_ff;
	logic [1:0]  strap_age_ff;
	logic [4:0]  station_ff;
	pmm_state_t  state_ff;
	logic [4:0]  cnt_ff;
	logic [11:0] shift_ff;
	logic        prev_bit_ff;
	logic        is_read_ff;
	logic        match_ff;
	logic [4:0]  reg_addr_ff;
	logic [15:0] rdata_ff;
	logic [15:0] ctrl_ff;
	logic [15:0] adv_ff;
	logic [15:0] np_ff;
	logic [15:0] v1_ff;
	logic [15:0] v2_ff;
	logic [15:0] v3_ff;
	logic        out_ff;
	logic        oe_ff;
	logic        rise;
	logic        fall;
	logic        bit_in;
	logic        wr_stb;
	logic [15:0] wr_data;
	logic [15:0] nxt_rdata;
	logic [2:0]  data_hi_ff;

	assign bit_in = mdio_sync_ff[1];
	assign rise = mdc_sync_ff[1] & ~mdc_prev_ff; // R20
	assign fall = ~mdc_sync_ff[1] & mdc_prev_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdc_sync_ff <= 2'h0;
			mdio_sync_ff <= 2'h3;
			mdc_prev_ff <= 1'b0;
		end else begin
			mdc_sync_ff <= {mdc_sync_ff[0], link.mdc};
			mdio_sync_ff <= {mdio_sync_ff[0], link.mdio_i};
			mdc_prev_ff <= mdc_sync_ff[1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_meta_ff <= 5'h00;
			strap_sync_ff <= 5'h00;
			strap_age_ff <= 2'h0;
			station_ff <= 5'h00;
		end else begin
			strap_meta_ff <= station_address_strap;
			strap_sync_ff <= strap_meta_ff;
			if (strap_age_ff != 2'h3) begin
				strap_age_ff <= strap_age_ff + 2'h1;
			end
			if (strap_age_ff == 2'h2) begin
				station_ff <= strap_sync_ff; // R17
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= PMM_IDLE;
			cnt_ff <= 5'h00;
			shift_ff <= 12'h000;
			prev_bit_ff <= 1'b1;
			is_read_ff <= 1'b0;
			match_ff <= 1'b0;
			reg_addr_ff <= 5'h00;
		end else if (rise) begin
			shift_ff <= {shift_ff[10:0], bit_in};
			prev_bit_ff <= bit_in;
			unique case (state_ff)
			PMM_IDLE: begin
				if (!prev_bit_ff && bit_in) begin // R6 R5 R4
					state_ff <= PMM_OP;
					cnt_ff <= 5'h00;
				end
			end
			PMM_OP: begin
				cnt_ff <= cnt_ff + 5'h01;
				if (cnt_ff == 5'h01) begin
					cnt_ff <= 5'h00;
					state_ff <= PMM_ADDR;
					is_read_ff <= ({shift_ff[0], bit_in} == pmm_pkg::OP_READ); // R7
					if ({shift_ff[0], bit_in} != pmm_pkg::OP_READ &&
						{shift_ff[0], bit_in} != pmm_pkg::OP_WRITE) begin
						state_ff <= PMM_IDLE;
					end
				end
			end
			PMM_ADDR: begin
				cnt_ff <= cnt_ff + 5'h01;
				if (cnt_ff == 5'h09) begin // R8 R10 R2
					cnt_ff <= 5'h00;
					state_ff <= PMM_TA;
					reg_addr_ff <= {shift_ff[3:0], bit_in};
					match_ff <= (shift_ff[8:4] == station_ff) ||
						(shift_ff[8:4] == pmm_pkg::BCAST_ADDR); // R9
				end
			end
			PMM_TA: begin
				cnt_ff <= cnt_ff + 5'h01;
				if (cnt_ff == 5'h01) begin // R11
					cnt_ff <= 5'h00;
					state_ff <= PMM_DATA;
				end
			end
			PMM_DATA: begin
				cnt_ff <= cnt_ff + 5'h01;
				if (cnt_ff == 5'h0F) begin // R13 R3
					cnt_ff <= 5'h00;
					state_ff <= PMM_IDLE;
					prev_bit_ff <= 1'b1;
				end
			end
			default: state_ff <= PMM_IDLE;
			endcase
		end
	end

	assign wr_stb = rise && state_ff == PMM_DATA && cnt_ff == 5'h0F &&
		!is_read_ff && match_ff;
	assign wr_data = {data_hi_ff, shift_ff, bit_in}; // R13

	always_comb begin
		nxt_rdata = 16'h0000;
		unique case (reg_addr_ff)
		pmm_pkg::REG_CONTROL: nxt_rdata = ctrl_ff;
		pmm_pkg::REG_STATUS: nxt_rdata = pmm_pkg::RST_STATUS
			| (16'h0001 << pmm_pkg::STATUS_NOPRE_BIT); // R5
		pmm_pkg::REG_ID_HIGH: nxt_rdata = pmm_pkg::ID_HIGH_VAL;
		pmm_pkg::REG_ID_LOW: nxt_rdata = pmm_pkg::ID_LOW_VAL;
		pmm_pkg::REG_ADVERTISE: nxt_rdata = adv_ff;
		pmm_pkg::REG_PARTNER: nxt_rdata = next_page_phase ?
			partner_next_page : partner_base_page; // R15
		pmm_pkg::REG_EXPANSION: nxt_rdata = pmm_pkg::RST_EXPANSION;
		pmm_pkg::REG_NEXT_PAGE: nxt_rdata = np_ff;
		pmm_pkg::REG_VENDOR_ONE: nxt_rdata = v1_ff; // R16
		pmm_pkg::REG_VENDOR_TWO: nxt_rdata = v2_ff;
		pmm_pkg::REG_VENDOR_THREE: nxt_rdata = v3_ff;
		default: nxt_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= pmm_pkg::RST_CONTROL; // R14
			adv_ff <= pmm_pkg::RST_ADVERTISE;
			np_ff <= pmm_pkg::RST_NEXT_PAGE;
			v1_ff <= pmm_pkg::RST_VENDOR_ONE;
			v2_ff <= pmm_pkg::RST_VENDOR_TWO;
			v3_ff <= pmm_pkg::RST_VENDOR_THREE;
		end else if (ctrl_ff[pmm_pkg::CTRL_RESET_BIT]) begin
			ctrl_ff <= pmm_pkg::RST_CONTROL;
			adv_ff <= pmm_pkg::RST_ADVERTISE;
			np_ff <= pmm_pkg::RST_NEXT_PAGE;
			v1_ff <= pmm_pkg::RST_VENDOR_ONE;
			v2_ff <= pmm_pkg::RST_VENDOR_TWO;
			v3_ff <= pmm_pkg::RST_VENDOR_THREE;
		end else if (wr_stb) begin // R18
			unique case (reg_addr_ff)
			pmm_pkg::REG_CONTROL: ctrl_ff <= wr_data & pmm_pkg::CTRL_RW_MASK;
			pmm_pkg::REG_ADVERTISE: adv_ff <= wr_data;
			pmm_pkg::REG_NEXT_PAGE: np_ff <= wr_data;
			pmm_pkg::REG_VENDOR_ONE: v1_ff <= wr_data;
			pmm_pkg::REG_VENDOR_TWO: v2_ff <= wr_data;
			pmm_pkg::REG_VENDOR_THREE: v3_ff <= wr_data;
			default: ;
			endcase
		end else begin
			ctrl_ff[pmm_pkg::CTRL_RESTART_BIT] <= 1'b0;
		end
	end

	// Keeps the three oldest data bits that fall out of the shift register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_hi_ff <= 3'h0;
		end else if (rise && state_ff == PMM_DATA) begin
			data_hi_ff <= {data_hi_ff[1:0], shift_ff[11]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= 16'h0000;
			out_ff <= 1'b1;
			oe_ff <= 1'b0;
		end else if (fall) begin // R20
			if (state_ff == PMM_TA && cnt_ff == 5'h01 && is_read_ff &&
				match_ff) begin
				out_ff <= 1'b0; // R12
				oe_ff <= 1'b1;
				rdata_ff <= nxt_rdata;
			end else if (state_ff == PMM_DATA && oe_ff) begin
				out_ff <= rdata_ff[15]; // R13
				rdata_ff <= {rdata_ff[14:0], 1'b0};
			end else begin
				out_ff <= 1'b1; // R19
				oe_ff <= 1'b0;
			end
		end
	end

	assign link.mdio_dev_o = out_ff;
	assign link.mdio_dev_oe = oe_ff;
	assign control_out = ctrl_ff;
	assign powerdown = ctrl_ff[pmm_pkg::CTRL_PWRDN_BIT];
endmodule

/* hw/pmm_host.sv */
// Management controller driven by software over APB.
`timescale 1ns/1ps
module pmm_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	pmm_if.host              link
);
	typedef enum logic [1:0] {
		PMH_IDLE = 2'h0,
		PMH_RUN  = 2'h1
	} pmh_state_t;

	logic [1:0]  mdio_sync_ff;
	pmh_state_t  state_ff;
	logic [5:0]  div_ff;
	logic        mdc_ff;
	logic [6:0]  bit_ff;
	logic [63:0] frame_ff;
	logic        rd_ff;
	logic [15:0] wdata_ff;
	logic [15:0] rdata_ff;
	logic        oe_ff;
	logic        acc_wr;
	logic        start;
	logic        tick;

	assign acc_wr = psel && penable && pwrite;
	assign start = acc_wr && paddr[7:0] == pmm_pkg::APB_CMD[7:0] &&
		state_ff == PMH_IDLE;
	assign tick = div_ff == 6'(pmm_pkg::MDC_HALF_CYC - 1); // R1
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdio_sync_ff <= 2'h3;
		end else begin
			mdio_sync_ff <= {mdio_sync_ff[0], link.mdio_i};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata_ff <= 16'h0000;
		end else if (acc_wr && paddr[7:0] == pmm_pkg::APB_WDATA[7:0]) begin
			wdata_ff <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= PMH_IDLE;
			div_ff <= 6'h00;
			mdc_ff <= 1'b0;
			bit_ff <= 7'h00;
			frame_ff <= 64'h0;
			rd_ff <= 1'b0;
			oe_ff <= 1'b0;
			rdata_ff <= 16'h0000;
		end else if (start) begin
			state_ff <= PMH_RUN;
			div_ff <= 6'h00;
			mdc_ff <= 1'b0;
			bit_ff <= 7'h00;
			rd_ff <= pwdata[10];
			oe_ff <= 1'b1;
			frame_ff <= {32'hFFFF_FFFF, pmm_pkg::START_PAT, // R4 R2 R6
				pwdata[10] ? pmm_pkg::OP_READ : pmm_pkg::OP_WRITE, // R7
				pwdata[9:5], pwdata[4:0], pmm_pkg::TA_WRITE, // R8 R10 R11
				wdata_ff}; // R13
		end else if (state_ff == PMH_RUN) begin // R3
			div_ff <= tick ? 6'h00 : div_ff + 6'h01;
			if (tick) begin
				mdc_ff <= ~mdc_ff;
				if (mdc_ff) begin
					bit_ff <= bit_ff + 7'h01;
					frame_ff <= {frame_ff[62:0], 1'b0};
					oe_ff <= !(rd_ff && bit_ff >= 7'd45) &&
						bit_ff != 7'd63; // R12
					if (bit_ff == 7'd63) begin
						state_ff <= PMH_IDLE;
					end
				end else if (rd_ff && bit_ff >= 7'd48) begin
					rdata_ff <= {rdata_ff[14:0], mdio_sync_ff[1]};
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			prdata <= paddr[7:0] == pmm_pkg::APB_RDATA[7:0] ?
				{16'h0, rdata_ff} :
				paddr[7:0] == pmm_pkg::APB_STATUS[7:0] ?
				{31'h0, state_ff == PMH_RUN} : 32'h0;
		end
	end

	assign link.mdc = mdc_ff;
	assign link.mdio_host_o = frame_ff[63];
	assign link.mdio_host_oe = oe_ff;
endmodule

/* bench/pmm_link_props.sv */
// Checker for the management link between the two ends.
`timescale 1ns/1ps
module pmm_link_props (
	input logic pclk,
	input logic presetn,
	input logic mdc,
	input logic mdio_host_o,
	input logic mdio_host_oe,
	input logic mdio_dev_o,
	input logic mdio_dev_oe
);
	logic [8:0] dev_cnt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dev_cnt_ff <= 9'h000;
		else
			dev_cnt_ff <= mdio_dev_oe ? dev_cnt_ff + 9'h001 : 9'h000;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_NO_FIGHT: assert property (!(mdio_host_oe && mdio_dev_oe))
		else $error("both ends drive the line");
	AST_MDC_HIGH: assert property ($rose(mdc) |-> mdc [*8] ##1 !mdc)
		else $error("clock high phase wrong");
	AST_DEV_HOLD: assert property (mdc && $past(mdc) |->
		$stable(mdio_dev_o) && $stable(mdio_dev_oe))
		else $error("device output moved while clock high");
	AST_HOST_HOLD: assert property (mdc && $past(mdc) |->
		$stable(mdio_host_o) && $stable(mdio_host_oe))
		else $error("host output moved while clock high");
	AST_TA_ZERO: assert property ($rose(mdio_dev_oe) |-> !mdio_dev_o)
		else $error("turnaround bit not zero");
	AST_TA_FREE: assert property ($rose(mdio_dev_oe) |->
		!$past(mdio_host_oe, 8))
		else $error("host not released before turnaround");
	AST_DEV_SPAN: assert property ($fell(mdio_dev_oe) |->
		dev_cnt_ff >= 9'd264 && dev_cnt_ff <= 9'd280)
		else $error("device drove wrong number of bits");
	AST_DEV_OFF: assert property ($fell(mdio_dev_oe) |-> !mdc)
		else $error("device released while clock high");
endmodule

/* bench/tb_phy_mdio_management_slave.sv */
// Testbench joining the controller and the management slave.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t %h %h", $time, (a), (b)); end end
module tb_phy_mdio_management_slave;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, r;
	logic        pready, pslverr, np_sel = 0, pdn, mdc_q = 0, dev_seen = 0;
	logic [4:0]  strap = 0, a, b, ph, rg;
	logic [15:0] pb = 0, pn = 0, ctl, v;
	logic [63:0] frm = 0;
	int          bit_n = 0, error_cnt = 0, checks = 0;
	always #2.5 pclk = ~pclk;
	pmm_if lk();
	pmm_device i_pmm_device (.pclk(pclk), .presetn(presetn), .link(lk),
		.station_address_strap(strap), .partner_base_page(pb),
		.partner_next_page(pn), .next_page_phase(np_sel),
		.control_out(ctl), .powerdown(pdn));
	pmm_host i_pmm_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(lk));
	pmm_link_props i_pmm_link_props (.pclk(pclk), .presetn(presetn),
		.mdc(lk.mdc), .mdio_host_o(lk.mdio_host_o),
		.mdio_host_oe(lk.mdio_host_oe), .mdio_dev_o(lk.mdio_dev_o),
		.mdio_dev_oe(lk.mdio_dev_oe));
	// Captures 64 line bits per frame at the rising clock edges.
	always @(posedge pclk) begin
		mdc_q <= lk.mdc;
		if (lk.mdio_dev_oe)
			dev_seen <= 1'b1;
		if (lk.mdc && !mdc_q && bit_n < 64 && (bit_n > 0 || lk.mdio_host_oe)) begin
			frm <= {frm[62:0], lk.mdio_i};
			bit_n <= bit_n + 1;
		end
	end
	function automatic logic [63:0] frame_of(input logic rd,
		input logic [4:0] p, g, input logic [15:0] d, input logic mine);
		logic [1:0] ta;
		ta = !rd ? pmm_pkg::TA_WRITE : (mine ? 2'h2 : 2'h3);
		return {32'hFFFF_FFFF, pmm_pkg::START_PAT,
			rd ? pmm_pkg::OP_READ : pmm_pkg::OP_WRITE, p, g, ta, d};
	endfunction
	function automatic logic [15:0] rst_of(input logic [4:0] g);
		case (g)
			pmm_pkg::REG_CONTROL: return pmm_pkg::RST_CONTROL;
			pmm_pkg::REG_STATUS: return pmm_pkg::RST_STATUS;
			pmm_pkg::REG_ID_HIGH: return pmm_pkg::ID_HIGH_VAL;
			pmm_pkg::REG_ID_LOW: return pmm_pkg::ID_LOW_VAL;
			pmm_pkg::REG_ADVERTISE: return pmm_pkg::RST_ADVERTISE;
			pmm_pkg::REG_PARTNER: return pb;
			pmm_pkg::REG_VENDOR_TWO: return pmm_pkg::RST_VENDOR_TWO;
			default: return 16'h0000;
		endcase
	endfunction
	task apb(input logic w, input logic [31:0] ad, d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Runs one frame and checks what crossed the line.
	task mm(input logic rd, input logic [4:0] p, g, input logic [15:0] d,
		input logic mine);
		bit_n = 0;
		dev_seen = 1'b0;
		apb(1'b1, pmm_pkg::APB_WDATA, {16'h0000, d});
		apb(1'b1, pmm_pkg::APB_CMD, {21'h0, rd, p, g});
		do begin
			apb(1'b0, pmm_pkg::APB_STATUS, 32'h0);
		end while (r[0] !== 1'b0);
		if (rd) begin
			apb(1'b0, pmm_pkg::APB_RDATA, 32'h0);
			`CHK(r[15:0], d)
		end
		`CHK(bit_n, 64)
		`CHK(frm, frame_of(rd, p, g, d, mine))
		if (!mine)
			`CHK(dev_seen, 1'b0)
	endtask
	task done(input string s);
		$display("test %s finished", s);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#450000;
		error_cnt++;
		close_out();
	end
	initial begin
		void'($urandom(58810));
		a = 5'($urandom_range(30, 1));
		b = ~a;
		strap = a;
		pb = 16'($urandom);
		pn = 16'($urandom);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		strap <= b;
		for (int i = 0; i < 31; i++)
			mm(1'b1, a, 5'(i), rst_of(5'(i)), 1'b1);
		done("reset values");
		for (int i = 0; i < 8; i++) begin
			v = 16'($urandom);
			ph = i[0] ? a : pmm_pkg::BCAST_ADDR;
			rg = i[1] ? pmm_pkg::REG_ADVERTISE : pmm_pkg::REG_NEXT_PAGE;
			mm(1'b0, ph, rg, v, 1'b1);
			mm(1'b1, ph ^ a, rg, v, 1'b1);
		end
		done("random writes");
		mm(1'b0, b, pmm_pkg::REG_ADVERTISE, 16'h0F0F, 1'b0);
		mm(1'b1, b, pmm_pkg::REG_ADVERTISE, 16'hFFFF, 1'b0);
		mm(1'b1, a, pmm_pkg::REG_ADVERTISE, v, 1'b1);
		done("foreign address");
		mm(1'b0, a, pmm_pkg::REG_STATUS, 16'h0000, 1'b1);
		mm(1'b1, a, pmm_pkg::REG_STATUS, pmm_pkg::RST_STATUS, 1'b1);
		mm(1'b0, a, 5'h0C, 16'hFFFF, 1'b1);
		mm(1'b1, a, 5'h0C, 16'h0000, 1'b1);
		done("read only");
		v = (16'($urandom) & 16'h7D80) | 16'h0800;
		mm(1'b0, a, pmm_pkg::REG_CONTROL, v, 1'b1);
		mm(1'b1, a, pmm_pkg::REG_CONTROL, v, 1'b1);
		`CHK(ctl, v)
		`CHK(pdn, 1'b1)
		np_sel <= 1'b1;
		mm(1'b1, a, pmm_pkg::REG_PARTNER, pn, 1'b1);
		mm(1'b0, a, pmm_pkg::REG_CONTROL, 16'h8000, 1'b1);
		mm(1'b1, a, pmm_pkg::REG_ADVERTISE, pmm_pkg::RST_ADVERTISE, 1'b1);
		mm(1'b1, a, pmm_pkg::REG_CONTROL, pmm_pkg::RST_CONTROL, 1'b1);
		`CHK(pdn, 1'b0)
		done("control");
		close_out();
	end
endmodule
